// file: hdl/multi_io_read_front_end.sv
// Purpose: dual and quad i/o read front end of a serial flash
// Assumes: memory answers rd_data for rd_addr within two clk cycles
// Notes: link clock is sampled by clk; mode 0/3, in on rise, out on fall
// Behaviour
// - BBh: address and data on two lines
// - mode byte follows address on same lines
// - select 10 skips next opcode byte
// - other select values need opcode again
// - low nibble of mode byte ignored
// - mode reset clears continuous mode
// - EBh: four lines, four dummy clocks
// - EBh refused without quad enable
// - E7h: even address, two dummy clocks
// - E7h refused without quad enable
// - wrap setting persists for quad reads
// - wrap returns to section start until deselect
// - store wrap disable and length bits
// - skipping keeps each command's own opcode
// - wrap disabled after reset
// - 77h: 24 dummy bits, eight wrap bits
// - reset: 8 quad or 16 dual clocks ones
`timescale 1ns/1ps
`default_nettype none
`include "flash_rd_params.svh"

module multi_io_read_front_end (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic io_line_0_in,
  input wire logic io_line_1_in,
  input wire logic io_line_2_in,
  input wire logic io_line_3_in,
  output logic io_line_0_out,
  output logic io_line_1_out,
  output logic io_line_2_out,
  output logic io_line_3_out,
  output logic io_line_0_oe,
  output logic io_line_1_oe,
  output logic io_line_2_oe,
  output logic io_line_3_oe,
  // status from the status register block
  input wire logic quad_enable_bit,
  // memory array port
  output logic [23:0] rd_addr,
  input wire logic [7:0] rd_data,
  // state shown to the rest of the chip
  output logic cont_mode_active,
  output logic wrap_disable_bit,
  output logic [1:0] wrap_length_field
);

  ////////////////////////////////////////////////////////////
  // helpers

  // bits moved per clock
  function automatic logic [5:0] lanes(input flash_rd_pkg::cmd_t c);
    lanes = (c == flash_rd_pkg::CMD_DUAL) ? 6'h02 : 6'h04;
  endfunction

  // clocks that carry a number of bits
  function automatic logic [5:0] clocks(input flash_rd_pkg::cmd_t c, input logic [5:0] bits);
    clocks = (c == flash_rd_pkg::CMD_DUAL) ? (bits >> 1) : (bits >> 2);
  endfunction

  // shift in one clock's bits, higher line is the more significant bit
  function automatic logic [23:0] shin(input flash_rd_pkg::cmd_t c, input logic [23:0] v,
                                       input logic [3:0] io);
    shin = (c == flash_rd_pkg::CMD_DUAL) ? {v[21:0], io[1:0]} : {v[19:0], io};
  endfunction

  // dummy clocks for each command
  function automatic logic [5:0] dummies(input flash_rd_pkg::cmd_t c);
    case (c)
      flash_rd_pkg::CMD_QUAD: dummies = `DUMMY_QUAD;
      flash_rd_pkg::CMD_WORD: dummies = `DUMMY_WORD;
      default: dummies = `DUMMY_DUAL;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////
  // synchronised link

  logic cs_n_s;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic [3:0] io_s;

  link_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .cs_n_pin(cs_n),
    .sck_pin(sck),
    .io_pin({io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in}),
    .cs_n_s(cs_n_s),
    .cs_fall(cs_fall),
    .sck_rise(sck_rise),
    .sck_fall(sck_fall),
    .io_s(io_s)
  );

  ////////////////////////////////////////////////////////////
  // state

  flash_rd_pkg::state_t st_q; // phase of the transaction
  flash_rd_pkg::cmd_t cmd_q; // command in progress
  flash_rd_pkg::cmd_t cont_cmd_q; // implied command in continuous mode
  logic [5:0] cnt_q; // clocks spent in the phase
  logic [7:0] opc_q; // opcode bits so far
  logic [23:0] addr_q; // address bits so far
  logic [7:0] mode_q; // continuous-mode byte so far
  logic [7:0] wbits_q; // wrap bits so far
  logic cont_q; // continuous mode armed
  logic wrap_dis_q;
  logic [1:0] wrap_len_q;
  logic [23:0] rd_addr_q;
  logic [7:0] sh_q; // data byte being sent
  logic [1:0] beat_q; // clocks left in the current byte
  logic [3:0] out_q;
  logic [3:0] oe_q;

  logic [7:0] opc_full; // opcode including this clock's bit
  logic [7:0] mode_full; // mode byte including this clock's bits
  logic [23:0] mode_sh; // mode byte shifted at full width, trimmed below
  logic [7:0] wbits_full;
  logic [23:0] addr_full;
  logic last_opc;
  logic last_addr;
  logic last_mode;
  logic last_dummy;
  logic last_wrap;
  logic wrap_en;
  logic [23:0] next_addr;
  logic load_byte;

  assign opc_full = {opc_q[6:0], io_s[0]};
  assign addr_full = shin(cmd_q, addr_q, io_s);
  assign mode_sh = shin(cmd_q, {16'h0000, mode_q}, io_s);
  assign mode_full = mode_sh[7:0];
  assign wbits_full = {wbits_q[3:0], io_s};
  assign last_opc = (st_q == flash_rd_pkg::ST_OPC) && sck_rise && (cnt_q == `OPC_CLOCKS - 6'h01);
  assign last_addr = (st_q == flash_rd_pkg::ST_ADDR) && sck_rise
                     && (cnt_q == clocks(cmd_q, `ADDR_BITS) - 6'h01);
  assign last_mode = (st_q == flash_rd_pkg::ST_MODE) && sck_rise
                     && (cnt_q == clocks(cmd_q, `MODE_BITS) - 6'h01);
  assign last_dummy = (st_q == flash_rd_pkg::ST_DUMMY) && sck_rise
                      && (cnt_q == dummies(cmd_q) - 6'h01);
  assign last_wrap = (st_q == flash_rd_pkg::ST_WRAPCFG) && sck_rise
                     && (cnt_q == `WRAP_SET_CLOCKS - 6'h01);
  // wrap only touches the quad commands, dual stays linear
  assign wrap_en = !wrap_dis_q && (cmd_q != flash_rd_pkg::CMD_DUAL);
  assign load_byte = (st_q == flash_rd_pkg::ST_DATA) && sck_fall && (beat_q == 2'h0);

  addr_step u_step (
    .addr(rd_addr_q),
    .wrap_en(wrap_en),
    .wrap_len(wrap_len_q),
    .next(next_addr)
  );

  ////////////////////////////////////////////////////////////
  // phase sequencer; deselect always returns to idle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= flash_rd_pkg::ST_IDLE;
      cmd_q <= flash_rd_pkg::CMD_DUAL;
      cnt_q <= 6'h00;
    end
    else if (cs_n_s)
    begin
      st_q <= flash_rd_pkg::ST_IDLE;
      cnt_q <= 6'h00;
    end
    else if (cs_fall)
    begin
      cnt_q <= 6'h00;
      if (cont_q)
      begin
        // address comes first, command implied
        st_q <= flash_rd_pkg::ST_ADDR;
        cmd_q <= cont_cmd_q;
      end
      else
        st_q <= flash_rd_pkg::ST_OPC;
    end
    else if (sck_rise)
    begin
      cnt_q <= cnt_q + 6'h01;
      case (st_q)
        flash_rd_pkg::ST_OPC:
        begin
          if (last_opc)
          begin
            cnt_q <= 6'h00;
            case (opc_full)
              `OPC_DUAL_IO:
              begin
                st_q <= flash_rd_pkg::ST_ADDR;
                cmd_q <= flash_rd_pkg::CMD_DUAL;
              end
              `OPC_QUAD_IO:
              begin
                // refused while quad lines are not enabled
                st_q <= quad_enable_bit ? flash_rd_pkg::ST_ADDR : flash_rd_pkg::ST_IGNORE;
                cmd_q <= flash_rd_pkg::CMD_QUAD;
              end
              `OPC_WORD_IO:
              begin
                st_q <= quad_enable_bit ? flash_rd_pkg::ST_ADDR : flash_rd_pkg::ST_IGNORE;
                cmd_q <= flash_rd_pkg::CMD_WORD;
              end
              `OPC_WRAP_SET:
              begin
                st_q <= flash_rd_pkg::ST_WRAPCFG;
                cmd_q <= flash_rd_pkg::CMD_QUAD;
              end
              // mode reset and all other opcodes are not ours
              default: st_q <= flash_rd_pkg::ST_IGNORE;
            endcase
          end
        end
        flash_rd_pkg::ST_ADDR:
        begin
          if (last_addr)
          begin
            st_q <= flash_rd_pkg::ST_MODE;
            cnt_q <= 6'h00;
          end
        end
        flash_rd_pkg::ST_MODE:
        begin
          if (last_mode)
          begin
            // the dual read goes straight to data
            st_q <= (dummies(cmd_q) == 6'h00) ? flash_rd_pkg::ST_DATA : flash_rd_pkg::ST_DUMMY;
            cnt_q <= 6'h00;
          end
        end
        flash_rd_pkg::ST_DUMMY:
        begin
          if (last_dummy)
          begin
            st_q <= flash_rd_pkg::ST_DATA;
            cnt_q <= 6'h00;
          end
        end
        flash_rd_pkg::ST_WRAPCFG:
        begin
          if (last_wrap)
            st_q <= flash_rd_pkg::ST_IGNORE;
        end
        // data, ignore and idle just wait for deselect
        default: cnt_q <= 6'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // input shift registers, all but the address cleared at each selection
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      opc_q <= 8'h00;
      addr_q <= 24'h000000;
      mode_q <= 8'h00;
      wbits_q <= 8'h00;
    end
    else if (cs_fall)
    begin
      opc_q <= 8'h00;
      mode_q <= 8'h00;
      wbits_q <= 8'h00;
    end
    else if (sck_rise)
    begin
      if (st_q == flash_rd_pkg::ST_OPC)
        opc_q <= opc_full;
      if (st_q == flash_rd_pkg::ST_ADDR)
        addr_q <= addr_full;
      if (st_q == flash_rd_pkg::ST_MODE)
        mode_q <= mode_full;
      if (st_q == flash_rd_pkg::ST_WRAPCFG)
        wbits_q <= wbits_full;
    end
  end

  ////////////////////////////////////////////////////////////
  // continuous mode; all-ones clocks land here as a select of 11,
  // so a mode reset needs no separate decoder
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cont_q <= 1'h0;
      cont_cmd_q <= flash_rd_pkg::CMD_DUAL;
    end
    else if (last_mode)
    begin
      // only the select pair counts, other bits are don't care
      cont_q <= (mode_full[`CMODE_SEL_HI:`CMODE_SEL_LO] == `CMODE_ARM);
      cont_cmd_q <= cmd_q;
    end
  end

  ////////////////////////////////////////////////////////////
  // wrap configuration, held until the next set command
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrap_dis_q <= `WRAP_DIS_RST;
      wrap_len_q <= `WRAP_LEN_RST;
    end
    else if (last_wrap)
    begin
      wrap_dis_q <= wbits_full[`WRAP_DIS_POS];
      wrap_len_q <= wbits_full[`WRAP_LEN_HI:`WRAP_LEN_LO];
    end
  end

  ////////////////////////////////////////////////////////////
  // memory address: start at the given address, then step per byte
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rd_addr_q <= 24'h000000;
    else if (last_addr)
      rd_addr_q <= addr_full;
    else if (load_byte)
      rd_addr_q <= next_addr;
  end

  ////////////////////////////////////////////////////////////
  // data out on falling edges; drivers stay off until the first
  // data fall, which is the host's release point
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_q <= 8'h00;
      beat_q <= 2'h0;
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end
    else if (st_q != flash_rd_pkg::ST_DATA)
    begin
      beat_q <= 2'h0;
      oe_q <= 4'h0;
    end
    else if (sck_fall)
    begin
      // dual uses lines 0 and 1 only
      oe_q <= (cmd_q == flash_rd_pkg::CMD_DUAL) ? 4'h3 : 4'hF;
      if (load_byte)
      begin
        sh_q <= rd_data << lanes(cmd_q);
        out_q <= (cmd_q == flash_rd_pkg::CMD_DUAL) ? {2'h0, rd_data[7:6]} : rd_data[7:4];
        beat_q <= (cmd_q == flash_rd_pkg::CMD_DUAL) ? 2'h3 : 2'h1;
      end
      else
      begin
        sh_q <= sh_q << lanes(cmd_q);
        out_q <= (cmd_q == flash_rd_pkg::CMD_DUAL) ? {2'h0, sh_q[7:6]} : sh_q[7:4];
        beat_q <= beat_q - 2'h1;
      end
    end
  end

  assign {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out} = out_q;
  assign {io_line_3_oe, io_line_2_oe, io_line_1_oe, io_line_0_oe} = oe_q;
  assign rd_addr = rd_addr_q;
  assign cont_mode_active = cont_q;
  assign wrap_disable_bit = wrap_dis_q;
  assign wrap_length_field = wrap_len_q;

  ////////////////////////////////////////////////////////////
  // checks

  a_dual_two_lines:
    assert property (@(posedge clk) disable iff (!nrst)
      (cmd_q == flash_rd_pkg::CMD_DUAL) && (st_q == flash_rd_pkg::ST_DATA) |-> (oe_q[3:2] == 2'h0))
    else $error("dual read drives upper lines");

  a_oe_data_only:
    assert property (@(posedge clk) disable iff (!nrst)
      (oe_q != 4'h0) |-> $past(st_q) == flash_rd_pkg::ST_DATA)
    else $error("io driven outside data phase");

  a_cont_arm:
    assert property (@(posedge clk) disable iff (!nrst)
      cs_fall && cont_q |=> (st_q == flash_rd_pkg::ST_ADDR) && (cmd_q == $past(cont_cmd_q)))
    else $error("armed continuous mode did not skip opcode");

  a_cont_drop:
    assert property (@(posedge clk) disable iff (!nrst)
      last_mode && (mode_full[5:4] != 2'h2) |=> !cont_q)
    else $error("continuous mode kept after other select");

  a_low_nibble:
    assert property (@(posedge clk) disable iff (!nrst)
      last_mode |=> cont_q == ($past(mode_full[5:4]) == 2'h2))
    else $error("mode byte bits beyond select pair mattered");

  a_qe_refuse:
    assert property (@(posedge clk) disable iff (!nrst)
      last_opc && !quad_enable_bit && ((opc_full == 8'hEB) || (opc_full == 8'hE7)) && !cs_n_s
      |=> st_q == flash_rd_pkg::ST_IGNORE)
    else $error("quad read taken without quad enable");

  a_quad_dummy:
    assert property (@(posedge clk) disable iff (!nrst)
      (st_q == flash_rd_pkg::ST_DUMMY) && (cmd_q == flash_rd_pkg::CMD_QUAD) && sck_rise && !cs_n_s
      |=> (st_q == flash_rd_pkg::ST_DATA) == ($past(cnt_q) == 6'h03))
    else $error("quad read dummy count is not four");

  a_wrap_section:
    assert property (@(posedge clk) disable iff (!nrst)
      load_byte && wrap_en |=> rd_addr_q[23:6] == $past(rd_addr_q[23:6]))
    else $error("wrapped read left its section");

  a_linear_step:
    assert property (@(posedge clk) disable iff (!nrst)
      load_byte && !wrap_en |=> rd_addr_q == $past(rd_addr_q) + 24'h000001)
    else $error("linear read did not increment");

  a_wrap_store:
    assert property (@(posedge clk) disable iff (!nrst)
      last_wrap && !cs_n_s |=> {wrap_len_q, wrap_dis_q} == $past(wbits_full[6:4]))
    else $error("wrap bits not stored");

endmodule // multi_io_read_front_end

`default_nettype wire

// file: hdl/flash_rd_params.svh
// Purpose: opcodes, field positions, reset values and counts of the read front end
// Assumes: included by its bare name
// Notes: definitions only
`ifndef FLASH_RD_PARAMS_SVH
`define FLASH_RD_PARAMS_SVH

// opcodes, taken one bit per clock on io line 0
`define OPC_DUAL_IO 8'hBB
`define OPC_QUAD_IO 8'hEB
`define OPC_WORD_IO 8'hE7
`define OPC_WRAP_SET 8'h77
`define OPC_MODE_RST 8'hFF

// continuous-mode byte fields
`define CMODE_SEL_HI 5
`define CMODE_SEL_LO 4
`define CMODE_ARM 2'h2

// wrap configuration fields and power-up values
`define WRAP_DIS_POS 4
`define WRAP_LEN_HI 6
`define WRAP_LEN_LO 5
`define WRAP_DIS_RST 1'h1
`define WRAP_LEN_RST 2'h0

// section masks within a 256-byte page
`define WRAP_MASK_8 6'h07
`define WRAP_MASK_16 6'h0F
`define WRAP_MASK_32 6'h1F
`define WRAP_MASK_64 6'h3F

// phase lengths in bits or clocks
`define ADDR_BITS 6'h18
`define MODE_BITS 6'h08
`define OPC_CLOCKS 6'h08
`define WRAP_SET_CLOCKS 6'h08
`define DUMMY_DUAL 6'h00
`define DUMMY_QUAD 6'h04
`define DUMMY_WORD 6'h02

`endif

// file: hdl/flash_rd_pkg.sv
// Purpose: types shared by the read front end
// Assumes: nothing
// Notes: used as flash_rd_pkg::name
package flash_rd_pkg;

  // transaction phases
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_WRAPCFG, ST_IGNORE
  } state_t;

  // the three multi-line read commands
  typedef enum logic [1:0] {
    CMD_DUAL, CMD_QUAD, CMD_WORD
  } cmd_t;

endpackage

// file: hdl/link_sync.sv
// Purpose: brings the serial pins into the clk domain and finds clock edges
// Assumes: link clock period is many clk periods
// Notes: all pins share one delay, so data stays aligned to edges
`timescale 1ns/1ps
`default_nettype none

module link_sync (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // raw pins
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic [3:0] io_pin,
  // synchronised view
  output logic cs_n_s,
  output logic cs_fall,
  output logic sck_rise,
  output logic sck_fall,
  output logic [3:0] io_s
);

  logic [5:0] meta_q; // first stage, read only by sync_q
  logic [5:0] sync_q; // {cs_n, sck, io[3:0]}
  logic sck_prev_q;
  logic cs_prev_q;

  ////////////////////////////////////////////////////////////
  // two-stage synchroniser, idle levels at reset; sck idles low (mode 0)
  // so no false clock edge follows reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= 6'h20;
      sync_q <= 6'h20;
    end
    else
    begin
      meta_q <= {cs_n_pin, sck_pin, io_pin};
      sync_q <= meta_q;
    end
  end

  // previous levels for edge finding
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_prev_q <= 1'h0;
      cs_prev_q <= 1'h1;
    end
    else
    begin
      sck_prev_q <= sync_q[4];
      cs_prev_q <= sync_q[5];
    end
  end

  assign cs_n_s = sync_q[5];
  assign cs_fall = cs_prev_q & ~sync_q[5];
  assign sck_rise = sync_q[4] & ~sck_prev_q;
  assign sck_fall = ~sync_q[4] & sck_prev_q;
  assign io_s = sync_q[3:0];

endmodule // link_sync

`default_nettype wire

// file: hdl/addr_step.sv
// Purpose: next read address, linear or wrapped inside an aligned section
// Assumes: combinational, used once per byte
// Notes: linear step rolls over at the top of the 24-bit space
`timescale 1ns/1ps
`default_nettype none
`include "flash_rd_params.svh"

module addr_step (
  // current address and wrap setting
  input wire logic [23:0] addr,
  input wire logic wrap_en,
  input wire logic [1:0] wrap_len,
  // following address
  output logic [23:0] next
);

  logic [5:0] mask; // bits that move inside the section
  logic [5:0] low_inc;

  // section size from the length field, aligned to itself
  always_comb
  begin
    case (wrap_len)
      2'h0: mask = `WRAP_MASK_8;
      2'h1: mask = `WRAP_MASK_16;
      2'h2: mask = `WRAP_MASK_32;
      default: mask = `WRAP_MASK_64;
    endcase
  end

  assign low_inc = addr[5:0] + 6'h01;

  // wrapped: upper bits frozen, low bits roll inside the mask
  assign next = wrap_en ? {addr[23:6], (addr[5:0] & ~mask) | (low_inc & mask)}
                        : addr + 24'h000001;

endmodule // addr_step

`default_nettype wire

// file: verification/flash_host.sv
// Purpose: host controller model for the multi-line read link
// Assumes: lines change on clk falling edges
// Notes: sck idles low (mode 0), eight clk per link clock
`timescale 1ns/1ps
`default_nettype none

module flash_host (
  // clock
  input wire logic clk,
  // link pins
  output logic cs_n,
  output logic sck,
  output logic [3:0] io_o,
  output logic [3:0] io_e,
  input wire logic [3:0] io_w
);
  logic [7:0] rx[$]; // bytes taken in the data phase
  logic [3:0] got; // lines seen just before each fall

  // idle link: deselected, clock low, lines released
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    io_o = 4'h0;
    io_e = 4'h0;
  end

  // one link clock; released lines keep their last value so the wire shows its inverse
  task automatic tick(input logic [3:0] v, input logic [3:0] e);
    io_o = (io_o & ~e) | (v & e);
    io_e = e;
    repeat (4) @(negedge clk);
    sck = 1'b1;
    repeat (4) @(negedge clk);
    got = io_w;
    sck = 1'b0;
  endtask

  // one frame: opcode on line 0 unless skipped, 32 bits on w lines, dummies, data
  task automatic xfer(input logic [7:0] opc, input bit skip, input logic [31:0] val,
                      input int w, input int dum, input int nb);
    logic [3:0] m;
    logic [7:0] b;
    m = (w == 4) ? 4'hF : 4'h3;
    rx.delete();
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    if (!skip)
      for (int i = 7; i >= 0; i--)
        tick({3'h0, opc[i]}, 4'h1);
    for (int i = 32 - w; i >= 0; i -= w)
      tick(4'(val >> i) & m, m);
    // lines are let go before the first data clock can fall
    repeat (dum) tick(4'h0, 4'h0);
    for (int k = 0; k < nb; k++)
    begin
      for (int j = 0; j < 8 / w; j++)
      begin
        tick(4'h0, 4'h0);
        b = (b << w) | 8'(got & m);
      end
      rx.push_back(b);
    end
    cs_n = 1'b1;
    io_e = 4'h0;
    repeat (8) @(negedge clk);
  endtask
endmodule // flash_host

`default_nettype wire

// file: verification/tb_multi_io_read_front_end.sv
// Purpose: self-checking bench of the read front end
// Assumes: memory image is a simple address hash
// Notes: inputs change on clk falling edges
`timescale 1ns/1ps
`default_nettype none

module tb_multi_io_read_front_end;
  logic clk = 1'b0; // 10 MHz system clock
  logic nrst = 1'b0; // reset, held 3 cycles
  logic qe = 1'b0; // quad enable status
  logic cs_n, sck; // link pins from host
  logic [3:0] io_o, io_e, dout, doe, io_w; // line drivers and resolved wire
  logic [23:0] rd_addr; // memory port
  logic [7:0] rd_data;
  logic cont, wdis; // stored state
  logic [1:0] wlen;
  logic oe_seen = 1'b0; // device drove any line
  int num_errors = 0;
  int samples_checked = 0;
  int sz;
  localparam logic [23:0] LIN = 24'hFFFFFF; // no wrap mask

  always #50 clk = ~clk;

  // device wins, then host; nobody driving shows the inverse of the last value
  for (genvar g = 0; g < 4; g++)
  begin : g_wire
    assign io_w[g] = doe[g] ? dout[g] : io_e[g] ? io_o[g] : ~io_o[g];
  end

  // memory image answered at once
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  assign rd_data = mem(rd_addr);

  always @(posedge clk)
    if (|doe)
      oe_seen <= 1'b1;

  flash_host u_host (.clk(clk), .cs_n(cs_n), .sck(sck), .io_o(io_o), .io_e(io_e), .io_w(io_w));

  multi_io_read_front_end u_dut (
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck),
    .io_line_0_in(io_w[0]), .io_line_1_in(io_w[1]), .io_line_2_in(io_w[2]), .io_line_3_in(io_w[3]),
    .io_line_0_out(dout[0]), .io_line_1_out(dout[1]), .io_line_2_out(dout[2]), .io_line_3_out(dout[3]),
    .io_line_0_oe(doe[0]), .io_line_1_oe(doe[1]), .io_line_2_oe(doe[2]), .io_line_3_oe(doe[3]),
    .quad_enable_bit(qe), .rd_addr(rd_addr), .rd_data(rd_data),
    .cont_mode_active(cont), .wrap_disable_bit(wdis), .wrap_length_field(wlen));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // read frame; expected address stays inside the section given by mask
  task automatic rd(input logic [7:0] opc, input bit skip, input logic [23:0] a, input logic [7:0] m,
                    input int w, input int dum, input int nb, input logic [23:0] mask);
    logic [23:0] x;
    u_host.xfer(opc, skip, {a, m}, w, dum, nb);
    for (int i = 0; i < nb; i++)
    begin
      x = (a & ~mask) | ((a + 24'(i)) & mask);
      check("read byte", 32'(mem(x)), 32'(u_host.rx[i]));
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    check("wrap disable", 1, wdis);
    check("wrap length", 0, wlen);
    check("cont mode", 0, cont);
    rd(8'hBB, 0, 24'h00FFFE, 8'h25, 2, 0, 4, LIN);
    check("cont mode", 1, cont);
    rd(8'hBB, 1, 24'h001234, 8'h00, 2, 0, 2, LIN);
    check("cont mode", 0, cont);
    rd(8'hBB, 0, 24'h00ABCD, 8'h20, 2, 0, 1, LIN);
    u_host.xfer(8'hFF, 1, 32'hFFFFFFFF, 2, 0, 0);
    check("cont mode", 0, cont);
    // quad reads turned away while quad enable is low
    for (int i = 0; i < 2; i++)
    begin
      oe_seen = 1'b0;
      u_host.xfer(i ? 8'hE7 : 8'hEB, 0, 32'h00001000, 4, 4, 1);
      check("refused drive", 0, oe_seen);
    end
    qe = 1'b1;
    rd(8'hEB, 0, 24'h0000F6, 8'h2A, 4, 4, 4, LIN);
    rd(8'hEB, 1, 24'h0300F0, 8'h20, 4, 4, 2, LIN);
    u_host.xfer(8'hFF, 1, 32'hFFFFFFFF, 4, 0, 0);
    check("cont mode", 0, cont);
    // every wrap length, alternating the two quad commands
    for (int n = 0; n < 4; n++)
    begin
      u_host.xfer(8'h77, 0, {24'h0, 1'b0, 2'(n), 5'h00}, 4, 0, 0);
      check("wrap disable", 0, wdis);
      check("wrap length", n, wlen);
      sz = 8 << n;
      rd(n[0] ? 8'hE7 : 8'hEB, 0, 24'h123480 + 24'(sz) - 24'h4, 8'h00, 4, n[0] ? 2 : 4, sz + 3,
         24'(sz - 1));
    end
    rd(8'hBB, 0, 24'h0000FC, 8'h00, 2, 0, 6, LIN);
    u_host.xfer(8'h77, 0, 32'h00000010, 4, 0, 0);
    check("wrap disable", 1, wdis);
    rd(8'hEB, 0, 24'h00003C, 8'h00, 4, 4, 8, LIN);
    // word read in continuous mode keeps its own two dummies
    rd(8'hE7, 0, 24'h000200, 8'h2F, 4, 2, 2, LIN);
    check("cont mode", 1, cont);
    rd(8'hE7, 1, 24'h000310, 8'h00, 4, 2, 2, LIN);
    check("cont mode", 0, cont);
    stop_test();
  end

  // watchdog, several times the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule // tb_multi_io_read_front_end

`default_nettype wire
